// file: prx_consts.svh
// register offsets, field positions, reset values and codes of the proximity control bank
// assumes inclusion by bare name from the package and the test bench
//
// Summary of operation
// - soft reset bit restores defaults, aborts, sleeps; the code stops the oscillator for one cycle only, then follows i_power_on
// - clear-on-read bit clears status flags on read
// - interrupt after cycle with sleep bit stops oscillator
// - clearing pending interrupts restarts stopped oscillator
// - pulse_control_off bit turns off automatic pulse control
// - offset magnitude register, read-write, resets to zero
// - bit 0 of sign register holds offset sign
// - signed offset applied to result, range 255
// - calibration type bit: both crosstalks or electrical
// - offset_calibration_ctrl_start bit launches offset calibration sequence
// - search adjusts offset until result nears target
// - electrical calibration disconnects photodiode throughout sequence
// - electrical calibration accepted whenever no calibration is running
// - finished calibration sets offset_calibration_ctrl_done_flag
// - calibration result written into offset registers
// - target code n selects 2^(n+2)-1, default 15
`ifndef PRX_CONSTS_SVH
`define PRX_CONSTS_SVH

`define PRX_ADDR_STATUS       8'h93
`define PRX_ADDR_SOFT_RST     8'hA0
`define PRX_ADDR_INT_BEHAV    8'hAB
`define PRX_ADDR_TUNING       8'hAC
`define PRX_ADDR_PULSE_CTRL   8'hAE
`define PRX_ADDR_OFFS_MAG     8'hC0
`define PRX_ADDR_OFFS_SIGN    8'hC1
`define PRX_ADDR_CAL_CTRL     8'hD7
`define PRX_ADDR_CAL_SEARCH   8'hD9

`define PRX_RST_INT_BEHAV     8'h04
`define PRX_RST_TUNING        8'h3F
`define PRX_RST_PULSE_CTRL    8'h3F
`define PRX_RST_OFFS_MAG      8'h00
`define PRX_RST_OFFS_SIGN     8'h00
`define PRX_RST_CAL_CTRL      8'h00
`define PRX_RST_CAL_SEARCH    8'h50

`define PRX_BIT_SOFT_RST      0
`define PRX_BIT_CLR_ON_READ   7
`define PRX_BIT_SLEEP_AFT_INT 4
`define PRX_BIT_PULSE_OFF     6
`define PRX_BIT_OFFS_SIGN     0
`define PRX_BIT_CAL_ELEC      5
`define PRX_BIT_CAL_START     0
`define PRX_BIT_ST_CAL_DONE   3
`define PRX_BIT_ST_LIGHT      4
`define PRX_BIT_ST_PROX       5
`define PRX_POS_TARGET_LO     5
`define PRX_POS_TARGET_HI     7
`define PRX_CAL_STEPS_TOP     4'h8

`endif

// file: prx_pkg.sv
// types shared by the proximity control bank
// assumes prx_consts.svh is on the include path
`include "prx_consts.svh"

package prx_pkg;

  typedef struct packed {
    logic       sign;
    logic [7:0] mag;
  } prx_offset_t;

  typedef enum logic [1:0] {
    PRX_CAL_IDLE = 2'b00,
    PRX_CAL_MEAS = 2'b01,
    PRX_CAL_DONE = 2'b10
  } prx_cal_state_t;

endpackage : prx_pkg

// file: prx_osc_gate.sv
// oscillator gating from power-on, sleep-after-interrupt and the active-interrupt state
// assumes all inputs come from logic on i_clk
`timescale 1ns/1ps

module prx_osc_gate (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_soft,
  input  wire logic i_power_on,
  input  wire logic i_sleep_aft_int,
  input  wire logic i_int_active,
  input  wire logic i_cycle_done,
  output logic      o_osc_en,
  output logic      o_asleep
);
  import prx_pkg::*;

  logic asleep_nxt;

  // latch the stop at cycle end, release once the interrupt is cleared
  always_comb begin
    asleep_nxt = o_asleep;
    if (i_soft || !i_int_active) begin
      asleep_nxt = 1'b0;
    end else if (i_cycle_done && i_sleep_aft_int) begin
      asleep_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_asleep <= 1'b0;
    end else begin
      o_asleep <= asleep_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_osc_en <= 1'b0;
    end else begin
      o_osc_en <= i_power_on && !i_soft && !(i_sleep_aft_int && asleep_nxt);
    end
  end

endmodule : prx_osc_gate

// file: prx_cal_search.sv
// successive-approximation search of the signed proximity offset
// assumes i_meas_result is the offset-adjusted result of the current trial
`timescale 1ns/1ps

module prx_cal_search (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_start,
  input  wire logic                i_abort,
  input  wire logic [8:0]          i_target,
  input  wire logic                i_meas_valid,
  input  wire logic [13:0]         i_meas_result,
  output logic                     o_meas_req,
  output logic                     o_busy,
  output logic                     o_done,
  output prx_pkg::prx_offset_t     o_trial
);
  import prx_pkg::*;

  prx_cal_state_t state_r;
  logic [8:0]     code_r;
  logic [3:0]     step_r;
  logic signed [9:0] off_s;

  // code 0..511 maps to offset -256..255, clamped at -255
  always_comb begin
    off_s = $signed({1'b0, code_r}) - 10'sd256;
    if (off_s < -10'sd255) begin
      off_s = -10'sd255;
    end
    o_trial.sign = off_s[9];
    o_trial.mag  = off_s[9] ? 8'((-off_s)) : off_s[7:0];
  end

  assign o_meas_req = (state_r == PRX_CAL_MEAS);
  assign o_busy     = (state_r != PRX_CAL_IDLE);
  assign o_done     = (state_r == PRX_CAL_DONE);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= PRX_CAL_IDLE;
      code_r  <= 9'h000;
      step_r  <= 4'h0;
    end else if (i_abort) begin
      state_r <= PRX_CAL_IDLE;
    end else begin
      unique case (state_r)
        PRX_CAL_IDLE: begin
          if (i_start) begin
            state_r <= PRX_CAL_MEAS;
            code_r  <= 9'h100;
            step_r  <= `PRX_CAL_STEPS_TOP;
          end
        end
        PRX_CAL_MEAS: begin
          if (i_meas_valid) begin
            // more offset lowers the result; drop the bit when it undershoots
            if ({5'h00, i_target} > i_meas_result) begin
              code_r[step_r] <= 1'b0;
            end
            if (step_r == 4'h0) begin
              state_r <= PRX_CAL_DONE;
            end else begin
              code_r[step_r - 4'h1] <= 1'b1;
              step_r                <= step_r - 4'h1;
            end
          end
        end
        PRX_CAL_DONE: begin
          state_r <= PRX_CAL_IDLE;
        end
        default: begin
          state_r <= PRX_CAL_IDLE;
        end
      endcase
    end
  end

endmodule : prx_cal_search

// file: prx_ctrl.sv
// control, configuration and offset calibration register bank of the proximity sensor
// assumes a serial-bus front end on i_clk giving byte register strobes, and
// measurement engines on i_clk giving cycle, flag and raw result pulses
`timescale 1ns/1ps

module prx_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_power_on,
  input  wire logic        i_light_irq_en,
  input  wire logic        i_prox_irq_en,
  input  wire logic        i_light_evt,
  input  wire logic        i_prox_evt,
  input  wire logic        i_cycle_done,
  input  wire logic        i_prox_raw_valid,
  input  wire logic [13:0] i_prox_raw,
  output logic      [13:0] o_prox_result,
  output logic             o_prox_result_valid,
  output logic             o_cal_meas_req,
  output logic             o_pd_disconnect,
  output logic             o_int_n,
  output logic             o_osc_en,
  output logic             o_soft_reset,
  output logic             o_pulse_ctrl_off,
  output logic      [7:0]  o_tuning_cfg
);
  import prx_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0]  int_behav_r;
  logic [7:0]  tuning_r;
  logic [7:0]  pulse_ctrl_r;
  logic [7:0]  cal_ctrl_r;
  logic [7:0]  cal_search_r;
  prx_offset_t offset_r;
  logic [7:0]  mag_r;
  logic [7:0]  sign_rsvd_r;
  logic        light_flag_r;
  logic        prox_flag_r;
  logic        cal_flag_r;

  logic        wr_soft;
  logic        wr_int_behav;
  logic        wr_tuning;
  logic        wr_pulse;
  logic        wr_mag;
  logic        wr_sign;
  logic        wr_cal;
  logic        wr_search;
  logic        wr_status;
  logic        rd_status;
  logic        clr_on_read;

  logic        cal_start;
  logic        cal_busy;
  logic        cal_done;
  logic        cal_req;
  prx_offset_t cal_trial;
  logic [8:0]  cal_target;
  logic        int_active;
  logic        asleep;

  prx_offset_t       off_use;
  logic signed [15:0] adj_s;
  logic [13:0]       adj_result;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign wr_soft      = i_reg_wr && (i_reg_addr == `PRX_ADDR_SOFT_RST)
                        && i_reg_wdata[`PRX_BIT_SOFT_RST];
  assign wr_int_behav = i_reg_wr && (i_reg_addr == `PRX_ADDR_INT_BEHAV);
  assign wr_tuning    = i_reg_wr && (i_reg_addr == `PRX_ADDR_TUNING);
  assign wr_pulse     = i_reg_wr && (i_reg_addr == `PRX_ADDR_PULSE_CTRL);
  assign wr_mag       = i_reg_wr && (i_reg_addr == `PRX_ADDR_OFFS_MAG);
  assign wr_sign      = i_reg_wr && (i_reg_addr == `PRX_ADDR_OFFS_SIGN);
  assign wr_cal       = i_reg_wr && (i_reg_addr == `PRX_ADDR_CAL_CTRL);
  assign wr_search    = i_reg_wr && (i_reg_addr == `PRX_ADDR_CAL_SEARCH);
  assign wr_status    = i_reg_wr && (i_reg_addr == `PRX_ADDR_STATUS);
  assign rd_status    = i_reg_rd && (i_reg_addr == `PRX_ADDR_STATUS);
  assign clr_on_read  = rd_status && int_behav_r[`PRX_BIT_CLR_ON_READ];

  assign o_soft_reset = wr_soft;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_behav_r <= `PRX_RST_INT_BEHAV;
    end else if (wr_soft) begin
      int_behav_r <= `PRX_RST_INT_BEHAV;
    end else if (wr_int_behav) begin
      int_behav_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tuning_r <= `PRX_RST_TUNING;
    end else if (wr_soft) begin
      tuning_r <= `PRX_RST_TUNING;
    end else if (wr_tuning) begin
      tuning_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_ctrl_r <= `PRX_RST_PULSE_CTRL;
    end else if (wr_soft) begin
      pulse_ctrl_r <= `PRX_RST_PULSE_CTRL;
    end else if (wr_pulse) begin
      pulse_ctrl_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cal_search_r <= `PRX_RST_CAL_SEARCH;
    end else if (wr_soft) begin
      cal_search_r <= `PRX_RST_CAL_SEARCH;
    end else if (wr_search) begin
      cal_search_r <= i_reg_wdata;
    end
  end

  assign o_tuning_cfg     = tuning_r;
  assign o_pulse_ctrl_off = pulse_ctrl_r[`PRX_BIT_PULSE_OFF];

  // ---------------------------------------------------------------
  // offset registers: host writes, calibration result wins
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mag_r <= `PRX_RST_OFFS_MAG;
    end else if (wr_soft) begin
      mag_r <= `PRX_RST_OFFS_MAG;
    end else if (cal_done) begin
      mag_r <= cal_trial.mag;
    end else if (wr_mag) begin
      mag_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sign_rsvd_r <= `PRX_RST_OFFS_SIGN;
    end else if (wr_soft) begin
      sign_rsvd_r <= `PRX_RST_OFFS_SIGN;
    end else if (cal_done) begin
      sign_rsvd_r[`PRX_BIT_OFFS_SIGN] <= cal_trial.sign;
    end else if (wr_sign) begin
      sign_rsvd_r <= i_reg_wdata;
    end
  end

  assign offset_r = {sign_rsvd_r[`PRX_BIT_OFFS_SIGN], mag_r};

  // ---------------------------------------------------------------
  // calibration control
  // ---------------------------------------------------------------
  assign cal_start = wr_cal && i_reg_wdata[`PRX_BIT_CAL_START] && !cal_busy;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cal_ctrl_r <= `PRX_RST_CAL_CTRL;
    end else if (wr_soft) begin
      cal_ctrl_r <= `PRX_RST_CAL_CTRL;
    end else if (cal_done) begin
      cal_ctrl_r[`PRX_BIT_CAL_START] <= 1'b0;
    end else if (wr_cal && !cal_busy) begin
      cal_ctrl_r <= i_reg_wdata;
    end
  end

  // code n gives 2^(n+2)-1
  assign cal_target = 9'((10'h004 << cal_search_r[`PRX_POS_TARGET_HI:`PRX_POS_TARGET_LO])
                         - 10'h001);

  prx_cal_search u_search (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_start       (cal_start),
    .i_abort       (wr_soft),
    .i_target      (cal_target),
    .i_meas_valid  (i_prox_raw_valid),
    .i_meas_result (adj_result),
    .o_meas_req    (cal_req),
    .o_busy        (cal_busy),
    .o_done        (cal_done),
    .o_trial       (cal_trial)
  );

  assign o_cal_meas_req = cal_req;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pd_disconnect <= 1'b0;
    end else begin
      o_pd_disconnect <= (cal_start && i_reg_wdata[`PRX_BIT_CAL_ELEC])
                         || (cal_busy && !cal_done && !wr_soft
                             && cal_ctrl_r[`PRX_BIT_CAL_ELEC]);
    end
  end

  // ---------------------------------------------------------------
  // offset applied to the proximity result
  // ---------------------------------------------------------------
  assign off_use = cal_busy ? cal_trial : offset_r;

  always_comb begin
    adj_s = $signed({2'b00, i_prox_raw});
    if (off_use.sign) begin
      adj_s = adj_s + $signed({8'h00, off_use.mag});
    end else begin
      adj_s = adj_s - $signed({8'h00, off_use.mag});
    end
    if (adj_s < 16'sd0) begin
      adj_result = 14'h0000;
    end else if (adj_s > 16'sh3FFF) begin
      adj_result = 14'h3FFF;
    end else begin
      adj_result = adj_s[13:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prox_result       <= 14'h0000;
      o_prox_result_valid <= 1'b0;
    end else begin
      o_prox_result_valid <= i_prox_raw_valid && !wr_soft;
      if (wr_soft) begin
        o_prox_result <= 14'h0000;
      end else if (i_prox_raw_valid) begin
        o_prox_result <= adj_result;
      end
    end
  end

  // ---------------------------------------------------------------
  // status flags: set wins over read and write clears, soft reset wins over set
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      light_flag_r <= 1'b0;
      prox_flag_r  <= 1'b0;
      cal_flag_r   <= 1'b0;
    end else if (wr_soft) begin
      light_flag_r <= 1'b0;
      prox_flag_r  <= 1'b0;
      cal_flag_r   <= 1'b0;
    end else begin
      light_flag_r <= i_light_evt || (light_flag_r && !clr_on_read
                      && !(wr_status && i_reg_wdata[`PRX_BIT_ST_LIGHT]));
      prox_flag_r  <= i_prox_evt || (prox_flag_r && !clr_on_read
                      && !(wr_status && i_reg_wdata[`PRX_BIT_ST_PROX]));
      cal_flag_r   <= cal_done || (cal_flag_r && !clr_on_read
                      && !(wr_status && i_reg_wdata[`PRX_BIT_ST_CAL_DONE]));
    end
  end

  assign int_active = (light_flag_r && i_light_irq_en) || (prox_flag_r && i_prox_irq_en);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_n <= 1'b1;
    end else begin
      o_int_n <= !int_active;
    end
  end

  // ---------------------------------------------------------------
  // oscillator gating
  // ---------------------------------------------------------------
  prx_osc_gate u_osc (
    .i_clk           (i_clk),
    .i_rst_n         (i_rst_n),
    .i_soft          (wr_soft),
    .i_power_on      (i_power_on),
    .i_sleep_aft_int (int_behav_r[`PRX_BIT_SLEEP_AFT_INT]),
    .i_int_active    (int_active),
    .i_cycle_done    (i_cycle_done),
    .o_osc_en        (o_osc_en),
    .o_asleep        (asleep)
  );

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `PRX_ADDR_STATUS:     o_reg_rdata <= {2'b00, prox_flag_r, light_flag_r,
                                              cal_flag_r, 3'b000};
        `PRX_ADDR_INT_BEHAV:  o_reg_rdata <= int_behav_r;
        `PRX_ADDR_TUNING:     o_reg_rdata <= tuning_r;
        `PRX_ADDR_PULSE_CTRL: o_reg_rdata <= pulse_ctrl_r;
        `PRX_ADDR_OFFS_MAG:   o_reg_rdata <= offset_r.mag;
        `PRX_ADDR_OFFS_SIGN:  o_reg_rdata <= sign_rsvd_r;
        `PRX_ADDR_CAL_CTRL:   o_reg_rdata <= cal_ctrl_r;
        `PRX_ADDR_CAL_SEARCH: o_reg_rdata <= cal_search_r;
        default:              o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  soft_reset_a: assert property (wr_soft |=> int_behav_r == `PRX_RST_INT_BEHAV
    && offset_r.mag == 8'h00 && !cal_busy && !o_osc_en)
    else $error("soft reset did not restore defaults");

  clear_read_a: assert property (clr_on_read && !wr_soft && !i_light_evt && !i_prox_evt
    && !cal_done |=> !light_flag_r && !prox_flag_r && !cal_flag_r)
    else $error("status flags survived a clearing read");

  osc_off_a: assert property (!i_power_on |=> !o_osc_en)
    else $error("oscillator running without power on");

  sleep_stop_a: assert property (i_cycle_done && int_active && !wr_soft
    && int_behav_r[`PRX_BIT_SLEEP_AFT_INT] |=> !o_osc_en ##0 asleep)
    else $error("oscillator kept running after interrupt");

  wake_up_a: assert property (asleep && !int_active && i_power_on && !wr_soft
    |=> o_osc_en && !asleep)
    else $error("oscillator not restarted after interrupt clear");

  pulse_off_a: assert property (wr_pulse && !wr_soft
    |=> o_pulse_ctrl_off == $past(i_reg_wdata[`PRX_BIT_PULSE_OFF]))
    else $error("pulse control off bit not taken");

  mag_write_a: assert property (wr_mag && !cal_done
    |=> offset_r.mag == $past(i_reg_wdata))
    else $error("offset magnitude write lost");

  offset_apply_a: assert property (i_prox_raw_valid && !cal_busy && !wr_soft
    && !offset_r.sign && {6'h00, offset_r.mag} <= i_prox_raw
    |=> o_prox_result == $past(i_prox_raw) - {6'h00, $past(offset_r.mag)})
    else $error("offset not applied to proximity result");

  done_flag_a: assert property (cal_done && !wr_soft |=> cal_flag_r && !cal_ctrl_r[0]
    && offset_r == $past(cal_trial))
    else $error("calibration end not reported");

  pd_off_a: assert property (cal_start && i_reg_wdata[`PRX_BIT_CAL_ELEC]
    |=> o_pd_disconnect && cal_busy)
    else $error("photodiode not disconnected for electrical calibration");

  cal_start_c: cover property (cal_start ##[1:300] cal_done);
  sleep_wake_c: cover property (asleep ##[1:100] o_osc_en);
  clr_read_c: cover property (clr_on_read && light_flag_r);

endmodule : prx_ctrl

// file: prx_host_model.sv
// host model: drives byte register strobes into the control bank
// assumes the bank samples strobes on the rising edge of i_clk
`timescale 1ns/1ps

module prx_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // one write; callers keep reserved fields at default
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr    = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_rd   = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd   = 1'b0;
    o_addr = ~a;
    d      = i_rdata;
  endtask : rd

  task automatic tune;
    wr(8'hAC, 8'h3D);
  endtask : tune
endmodule : prx_host_model

// file: prx_ctrl_test.sv
// self-checking bench of the proximity control bank
// assumes prx_pkg and the host model are compiled first
`timescale 1ns/1ps
`include "prx_consts.svh"

module prx_ctrl_test;
  import prx_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_power_on = 1'b1, i_prox_irq_en = 1'b1;
  logic i_light_evt = 1'b0, i_light_irq_en = 1'b1, o_prox_result_valid;
  logic i_prox_evt = 1'b0, i_cycle_done = 1'b0, i_prox_raw_valid = 1'b0, seen_soft = 1'b0;
  logic [13:0] i_prox_raw = 14'h0000;
  logic wr, rd, o_cal_meas_req, o_pd_disconnect, o_int_n, o_osc_en, o_soft_reset, o_pulse_ctrl_off;
  logic [7:0] addr, wdata, o_reg_rdata, o_tuning_cfg;
  logic [13:0] o_prox_result;
  int bad_count = 0, check_count = 0;

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_soft_reset === 1'b1) seen_soft <= 1'b1;

  prx_host_model prx_host_model_inst (.i_clk(i_clk), .i_rdata(o_reg_rdata), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  prx_ctrl prx_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(o_reg_rdata),
    .i_power_on(i_power_on), .i_light_irq_en(i_light_irq_en), .i_prox_irq_en(i_prox_irq_en),
    .i_light_evt(i_light_evt), .i_prox_evt(i_prox_evt), .i_cycle_done(i_cycle_done),
    .i_prox_raw_valid(i_prox_raw_valid), .i_prox_raw(i_prox_raw),
    .o_prox_result(o_prox_result), .o_prox_result_valid(o_prox_result_valid),
    .o_cal_meas_req(o_cal_meas_req),
    .o_pd_disconnect(o_pd_disconnect), .o_int_n(o_int_n), .o_osc_en(o_osc_en),
    .o_soft_reset(o_soft_reset), .o_pulse_ctrl_off(o_pulse_ctrl_off),
    .o_tuning_cfg(o_tuning_cfg));

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [13:0] e, input logic [13:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    prx_host_model_inst.rd(a, d);
    chk($sformatf("register %h", a), {6'h00, e}, {6'h00, d & m});
  endtask : rdchk

  task automatic wait_osc(input logic v);
    for (int n = 0; n < 20 && o_osc_en !== v; n++) begin
      @(posedge i_clk);
      #1;
    end
    chk("oscillator enable", {13'h0, v}, {13'h0, o_osc_en});
    if (o_osc_en !== v) test_done();
  endtask : wait_osc

  task automatic sample(input logic [13:0] raw, input logic [13:0] e);
    @(posedge i_clk);
    #1;
    i_prox_raw       = raw;
    i_prox_raw_valid = 1'b1;
    @(posedge i_clk);
    #1;
    i_prox_raw_valid = 1'b0;
    chk("prox result", e, o_prox_result);
    chk("prox result valid", 14'h1, {13'h0, o_prox_result_valid});
  endtask : sample

  task automatic cal_feed(input logic pd);
    for (int i = 0; i < 9; i++) begin
      chk("measure request", 14'h1, {13'h0, o_cal_meas_req});
      chk("photodiode off", {13'h0, pd}, {13'h0, o_pd_disconnect});
      @(posedge i_clk);
      #1;
      i_prox_raw_valid = 1'b1;
      @(posedge i_clk);
      #1;
      i_prox_raw_valid = 1'b0;
    end
    repeat (3) @(posedge i_clk);
    chk("measure request", 14'h0, {13'h0, o_cal_meas_req});
    chk("photodiode off", 14'h0, {13'h0, o_pd_disconnect});
    rdchk(8'h93, 8'h08, 8'h08);
  endtask : cal_feed

  task automatic t_reset;
    rdchk(8'hAB, 8'hFF, 8'h04);
    rdchk(8'hAC, 8'hFF, 8'h3F);
    rdchk(8'hAE, 8'hFF, 8'h3F);
    rdchk(8'hC0, 8'hFF, 8'h00);
    rdchk(8'hC1, 8'hFF, 8'h00);
    rdchk(8'hD7, 8'hFF, 8'h00);
    rdchk(8'hD9, 8'hFF, 8'h50);
    rdchk(8'h55, 8'hFF, 8'h00);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_offset;
    prx_host_model_inst.wr(8'hC0, 8'h10);
    sample(14'h0064, 14'h0054);
    prx_host_model_inst.wr(8'hC1, 8'h01);
    rdchk(8'hC1, 8'hFF, 8'h01);
    sample(14'h0064, 14'h0074);
    prx_host_model_inst.wr(8'hC1, 8'h00);
    prx_host_model_inst.wr(8'hC0, 8'hFF);
    rdchk(8'hC0, 8'hFF, 8'hFF);
    sample(14'h0010, 14'h0000);
    $display("test offset done");
  endtask : t_offset

  task automatic t_sleep;
    prx_host_model_inst.wr(8'hAB, 8'h94);
    wait_osc(1'b1);
    @(posedge i_clk);
    #1;
    i_prox_evt = 1'b1;
    i_light_evt = 1'b1;
    @(posedge i_clk);
    #1;
    i_prox_evt   = 1'b0;
    i_light_evt  = 1'b0;
    i_cycle_done = 1'b1;
    @(posedge i_clk);
    #1;
    i_cycle_done = 1'b0;
    chk("interrupt pin", 14'h0, {13'h0, o_int_n});
    wait_osc(1'b0);
    rdchk(8'h93, 8'h38, 8'h30);
    wait_osc(1'b1);
    chk("interrupt pin", 14'h1, {13'h0, o_int_n});
    rdchk(8'h93, 8'h38, 8'h00);
    prx_host_model_inst.wr(8'hAB, 8'h04);
    i_power_on = 1'b0;
    wait_osc(1'b0);
    i_power_on = 1'b1;
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_cal;
    prx_host_model_inst.wr(8'hC0, 8'h00);
    i_prox_raw = 14'h0000;
    prx_host_model_inst.wr(8'hD7, 8'h21);
    cal_feed(1'b1);
    rdchk(8'hD7, 8'hFF, 8'h20);
    rdchk(8'hC1, 8'hFF, 8'h01);
    rdchk(8'hC0, 8'hFF, 8'h0F);
    sample(14'h0000, 14'h000F);
    prx_host_model_inst.wr(8'h93, 8'h08);
    rdchk(8'h93, 8'h08, 8'h00);
    prx_host_model_inst.wr(8'hD7, 8'h01);
    cal_feed(1'b0);
    rdchk(8'hD7, 8'hFF, 8'h00);
    rdchk(8'hC0, 8'hFF, 8'h0F);
    $display("test calibration done");
  endtask : t_cal

  task automatic t_soft;
    prx_host_model_inst.wr(8'hAE, 8'h7F);
    chk("pulse control off", 14'h1, {13'h0, o_pulse_ctrl_off});
    prx_host_model_inst.tune();
    chk("tuning", 14'h003D, {6'h00, o_tuning_cfg});
    prx_host_model_inst.wr(8'hC0, 8'h22);
    prx_host_model_inst.wr(8'hD7, 8'h21);
    prx_host_model_inst.wr(8'hA0, 8'h01);
    chk("oscillator enable", 14'h0, {13'h0, o_osc_en});
    chk("measure request", 14'h0, {13'h0, o_cal_meas_req});
    chk("photodiode off", 14'h0, {13'h0, o_pd_disconnect});
    i_power_on = 1'b0;
    chk("soft reset pulse", 14'h1, {13'h0, seen_soft});
    chk("pulse control off", 14'h0, {13'h0, o_pulse_ctrl_off});
    chk("tuning", 14'h003F, {6'h00, o_tuning_cfg});
    rdchk(8'hC0, 8'hFF, 8'h00);
    rdchk(8'hC1, 8'hFF, 8'h00);
    wait_osc(1'b0);
    $display("test soft reset done");
  endtask : t_soft

  initial begin
    repeat (3) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    t_reset();
    t_offset();
    t_sleep();
    t_cal();
    t_soft();
    test_done();
  end

  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule : prx_ctrl_test
